// >>> core/iosup_top.sv
// io supervisor: operating-mode sequencer and safe-state control
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
module iosup_top
   import iosup_pkg::*;
#(
   parameter int TEST_CYC = TEST_CYCLES,   // self test length
   parameter int STEP_CYC = LED_STEP_CYC   // led pattern step
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RESET,
   input  wire logic [3:0]  ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   input  wire logic        PC_PRESENT,
   input  wire logic        WD_TIMEOUT,
   input  wire logic        MODULE_REMOVED,
   input  wire logic        TEST_PASS,
   input  wire logic [6:0]  ADDR_SWITCH,
   input  wire logic        FB_MODE_WR,
   input  wire logic [1:0]  FB_MODE_DATA,
   output logic      [1:0]  FB_MODE,
   output logic             FB_ENABLE,
   output logic             CONTROL_RUN,
   output logic             SAFE_STATE,
   output logic             INPUT_SCAN,
   output logic             DEV_ALARM_EN,
   output logic             FS_ALARM_EN,
   output logic             DEV_BLOCK_INIT,
   output logic             LOOP_ZERO,
   output logic             LOOP_BUMPLESS,
   output logic             RANGE_LIMIT,
   output logic             CFG_WRITE_EN,
   output logic             LED_YELLOW,
   output logic [2:0]       LED_TEST
);
   localparam int TW = $clog2(TEST_CYC + 1);  // test counter width
   localparam int SW = $clog2(STEP_CYC + 1);  // step counter width
   localparam logic [TW-1:0] TEST_LAST = TW'(TEST_CYC - 1);
   localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYC - 1);
   // baud readback unit, kilobaud per count
   localparam int BAUD_UNIT_KBD = 100;

   // valid fieldbus mode code
   function automatic logic mode_ok(input logic [1:0] m);
      mode_ok = (m == MODE_OPER) || (m == MODE_STANDBY) ||
                (m == MODE_CONFIG);
   endfunction

   // synchronised pins
   logic       pc_s;          // configuration pc attached
   logic       wd_s;          // watchdog timeout seen
   logic       rem_s;         // base removal seen
   logic       pass_s;        // self test result
   logic [6:0] sw_s;          // address switch

   iosup_sync #(.W(11)) u_sync (
      .SYS_CLK (SYS_CLK),
      .RESET   (RESET),
      .d       ({PC_PRESENT, WD_TIMEOUT, MODULE_REMOVED, TEST_PASS,
                 ADDR_SWITCH}),
      .q       ({pc_s, wd_s, rem_s, pass_s, sw_s})
   );

   iosup_state_t   state_r;        // supervisor state
   iosup_state_t   state_nxt;      // next state
   logic [TW-1:0]  test_cnt_r;     // self test timer
   logic [SW-1:0]  step_cnt_r;     // led step divider
   logic [2:0]     led_r;          // led pattern step
   logic           test_fail_r;    // sticky test failure
   logic           start_stby_r;   // stored start-in-standby option
   logic           wd_en_r;        // watchdog enabled
   logic           cfg_fb_r;       // config entered over fieldbus
   logic           rst_req;        // software reset-mode request
   logic           cfg_exit;       // config tool exit command
   logic           addr_ok;        // switch address valid
   logic           in_stby;        // standby or config behaviour
   logic           stop_ctl;       // control stopped
   logic           mode_wr;        // valid fieldbus mode write
   logic           was_stby_r;     // previous standby behaviour
   logic [7:0]     status;         // status word

   // software command pulses
   assign rst_req  = WR && (ADDR == ADDR_CTRL) && WDATA[CTRL_RESET_REQ];
   assign cfg_exit = WR && (ADDR == ADDR_CTRL) && WDATA[CTRL_CFG_EXIT];
   // fieldbus writes dead while pc attached
   assign mode_wr  = FB_MODE_WR && mode_ok(FB_MODE_DATA) && !pc_s;

   assign addr_ok  = (sw_s >= ADDR_MIN) && (sw_s <= ADDR_MAX);

   assign in_stby  = (state_r == ST_STBY_S) || (state_r == ST_CFG_S);

   // stop conditions
   // watchdog only counts when software armed it
   assign stop_ctl = (state_r != ST_OPER_S) || (wd_en_r && wd_s) ||
                     rem_s;

   // next state logic
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET_S: begin
            state_nxt = ST_TEST_S;
         end
         ST_TEST_S: begin
            if (test_cnt_r == TEST_LAST) begin
               state_nxt = ST_SEL_S;
            end
         end
         ST_SEL_S: begin
            if (pc_s) begin
               state_nxt = ST_CFG_S;
            end else if (start_stby_r) begin
               state_nxt = ST_STBY_S;
            end else begin
               state_nxt = ST_OPER_S;
            end
         end
         ST_OPER_S, ST_STBY_S: begin
            if (mode_wr) begin
               case (FB_MODE_DATA)
                  MODE_OPER:    state_nxt = ST_OPER_S;
                  MODE_STANDBY: state_nxt = ST_STBY_S;
                  default:      state_nxt = ST_CFG_S;
               endcase
            end
         end
         ST_CFG_S: begin
            if (cfg_exit || (mode_wr && FB_MODE_DATA == MODE_OPER)) begin
               state_nxt = ST_OPER_S;
            end else if (mode_wr && FB_MODE_DATA == MODE_STANDBY &&
                         !cfg_fb_r) begin
               state_nxt = ST_STBY_S;
            end
         end
         default: begin
            state_nxt = ST_RESET_S;
         end
      endcase
      if (rst_req) begin
         state_nxt = ST_RESET_S;
      end
   end

   // state register
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         state_r <= ST_RESET_S;
      end else begin
         state_r <= state_nxt;
      end
   end

   // config-via-fieldbus marker
   // a pc-entered config can still step to standby
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         cfg_fb_r <= 1'b0;
      end else if (state_nxt != ST_CFG_S) begin
         cfg_fb_r <= 1'b0;
      end else if (mode_wr && FB_MODE_DATA == MODE_CONFIG) begin
         cfg_fb_r <= 1'b1;
      end
   end

   // self test timer and led stepping
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         test_cnt_r  <= '0;
         step_cnt_r  <= '0;
         led_r       <= 3'h0;
         test_fail_r <= 1'b0;
      end else if (state_r != ST_TEST_S) begin
         // counters idle outside the test
         test_cnt_r <= '0;
         step_cnt_r <= '0;
         if (state_r == ST_RESET_S) begin
            test_fail_r <= 1'b0;
            led_r       <= 3'h0;
         end
      end else begin
         test_cnt_r <= test_cnt_r + TW'(1);
         // result judged on the last test cycle only; the pin sync
         // reads low for two cycles after reset, which would fail
         // every power-up if sampled earlier
         if ((test_cnt_r == TEST_LAST) && !pass_s) begin
            test_fail_r <= 1'b1;
         end
         if (step_cnt_r == STEP_LAST) begin
            step_cnt_r <= '0;
            led_r      <= led_r + 3'h1;
         end else begin
            step_cnt_r <= step_cnt_r + SW'(1);
         end
      end
   end

   // control register, software written
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         start_stby_r <= 1'b0;
         wd_en_r      <= 1'b0;
      end else if (WR && ADDR == ADDR_CTRL) begin
         start_stby_r <= WDATA[CTRL_START_STBY];
         wd_en_r      <= WDATA[CTRL_WD_EN];
      end
   end

   // status word assembly
   always_comb begin
      status               = 8'h00;
      status[ST_CONTROL]   = !stop_ctl;
      status[ST_SAFE]      = stop_ctl;
      status[ST_YELLOW]    = in_stby;
      status[ST_FB_EN]     = !pc_s && addr_ok;
      status[ST_ADDR_OK]   = addr_ok;
      status[ST_TEST_BUSY] = (state_r == ST_TEST_S);
      status[ST_TEST_FAIL] = test_fail_r;
      status[ST_CFG_FB]    = cfg_fb_r;
   end

   // read port, data one cycle after strobe
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            ADDR_MODE:   RDATA <= {6'h00, FB_MODE};
            ADDR_CTRL:   RDATA <= {6'h00, wd_en_r, start_stby_r};
            ADDR_STATUS: RDATA <= status;
            ADDR_SLAVE:  RDATA <= {addr_ok, sw_s};
            // top rate in 100 kbaud units
            ADDR_BAUD:   RDATA <= 8'(BAUD_MAX_KBD / BAUD_UNIT_KBD);
            default:     RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   // edge memory for leaving standby
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         was_stby_r <= 1'b0;
      end else begin
         was_stby_r <= in_stby;
      end
   end

   // registered outputs to the modules and fieldbus
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         FB_MODE        <= MODE_CONFIG;
         FB_ENABLE      <= 1'b0;
         CONTROL_RUN    <= 1'b0;
         SAFE_STATE     <= 1'b1;
         INPUT_SCAN     <= 1'b0;
         DEV_ALARM_EN   <= 1'b0;
         FS_ALARM_EN    <= 1'b0;
         DEV_BLOCK_INIT <= 1'b0;
         LOOP_ZERO      <= 1'b1;
         LOOP_BUMPLESS  <= 1'b0;
         RANGE_LIMIT    <= 1'b1;
         CFG_WRITE_EN   <= 1'b0;
         LED_YELLOW     <= 1'b0;
         LED_TEST       <= 3'h0;
      end else begin
         case (state_r)
            ST_OPER_S: FB_MODE <= MODE_OPER;
            ST_STBY_S: FB_MODE <= MODE_STANDBY;
            default:   FB_MODE <= MODE_CONFIG;
         endcase
         FB_ENABLE    <= !pc_s && addr_ok;
         CONTROL_RUN  <= !stop_ctl;
         SAFE_STATE   <= stop_ctl;
         INPUT_SCAN   <= (state_r == ST_OPER_S) || in_stby;
         DEV_ALARM_EN <= (state_r == ST_OPER_S);
         FS_ALARM_EN  <= (state_r == ST_OPER_S) || in_stby;
         DEV_BLOCK_INIT <= was_stby_r && !in_stby &&
                           (state_r == ST_OPER_S);
         LOOP_ZERO     <= stop_ctl;
         LOOP_BUMPLESS <= was_stby_r && !in_stby;
         // range clip always on
         // never released, so outputs cannot dip below their floor
         RANGE_LIMIT   <= 1'b1;
         CFG_WRITE_EN  <= (state_r == ST_CFG_S);
         LED_YELLOW    <= in_stby;
         LED_TEST      <= (state_r == ST_TEST_S) ? led_r :
                          {test_fail_r, 2'h0};
      end
   end
endmodule

// >>> core/iosup_pkg.sv
// constants and types for the io supervisor mode sequencer
package iosup_pkg;
   // operating-mode codes as reported and written over the fieldbus
   localparam logic [1:0] MODE_OPER    = 2'h0;
   localparam logic [1:0] MODE_STANDBY = 2'h1;
   localparam logic [1:0] MODE_CONFIG  = 2'h2;
   // register offsets of the plain register port
   localparam logic [3:0] ADDR_MODE    = 4'h0;
   localparam logic [3:0] ADDR_CTRL    = 4'h1;
   localparam logic [3:0] ADDR_STATUS  = 4'h2;
   localparam logic [3:0] ADDR_SLAVE   = 4'h3;
   localparam logic [3:0] ADDR_BAUD    = 4'h4;
   // control register fields
   localparam int CTRL_START_STBY = 0;
   localparam int CTRL_WD_EN      = 1;
   localparam int CTRL_CFG_EXIT   = 2;
   localparam int CTRL_RESET_REQ  = 3;
   // status register fields
   localparam int ST_CONTROL   = 0;
   localparam int ST_SAFE      = 1;
   localparam int ST_YELLOW    = 2;
   localparam int ST_FB_EN     = 3;
   localparam int ST_ADDR_OK   = 4;
   localparam int ST_TEST_BUSY = 5;
   localparam int ST_TEST_FAIL = 6;
   localparam int ST_CFG_FB    = 7;
   // address switch limits
   localparam logic [6:0] ADDR_MIN = 7'h01;
   localparam logic [6:0] ADDR_MAX = 7'h7f;
   // highest supported fieldbus rate, kilobaud
   localparam int BAUD_MAX_KBD = 12000;
   // self test timing
   localparam int CLK_MHZ       = 100;
   localparam int TEST_TIME_MS  = 5000;
   localparam int TEST_CYCLES   = TEST_TIME_MS * 1000 * CLK_MHZ;
   localparam int LED_STEP_MS   = 500;
   localparam int LED_STEP_CYC  = LED_STEP_MS * 1000 * CLK_MHZ;
   // supervisor states, gray along power-up path except select to standby
   typedef enum logic [2:0] {
      ST_RESET_S = 3'b000,
      ST_TEST_S  = 3'b001,
      ST_SEL_S   = 3'b011,
      ST_OPER_S  = 3'b010,
      ST_STBY_S  = 3'b110,
      ST_CFG_S   = 3'b111
   } iosup_state_t;
endpackage

// >>> core/iosup_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module iosup_sync #(
   parameter int W = 1
) (
   input  wire logic         SYS_CLK,
   input  wire logic         RESET,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;   // first stage, read only by q
   // two stages, constants on reset
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// >>> verification/iosup_chk.sv
// checker for the io supervisor top-level ports
`timescale 1ns/100ps
module iosup_chk
   import iosup_pkg::*;
(
   input wire logic       SYS_CLK,
   input wire logic       RESET,
   input wire logic       WR,
   input wire logic       PC_PRESENT,
   input wire logic [6:0] ADDR_SWITCH,
   input wire logic       FB_MODE_WR,
   input wire logic [1:0] FB_MODE_DATA,
   input wire logic [1:0] FB_MODE,
   input wire logic       FB_ENABLE,
   input wire logic       CONTROL_RUN,
   input wire logic       SAFE_STATE,
   input wire logic       INPUT_SCAN,
   input wire logic       DEV_ALARM_EN,
   input wire logic       FS_ALARM_EN,
   input wire logic       DEV_BLOCK_INIT,
   input wire logic       LOOP_ZERO,
   input wire logic       LOOP_BUMPLESS,
   input wire logic       RANGE_LIMIT,
   input wire logic       CFG_WRITE_EN,
   input wire logic       LED_YELLOW
);
   // one clock domain, so one default for all
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   a_safe_compl: assert property (SAFE_STATE == !CONTROL_RUN)
      else $error("safe state not the complement of control");
   a_run_oper: assert property (CONTROL_RUN |-> FB_MODE == MODE_OPER)
      else $error("control running outside operating mode");
   a_standby_out: assert property (LED_YELLOW |-> !CONTROL_RUN && INPUT_SCAN
      && !DEV_ALARM_EN && FS_ALARM_EN && LOOP_ZERO)
      else $error("standby outputs wrong");
   a_cfg_write: assert property (CFG_WRITE_EN |-> FB_MODE == MODE_CONFIG
      && LED_YELLOW)
      else $error("config write outside config mode");
   // port held connected for longer than the pin sync path
   a_pc_fb_off: assert property (PC_PRESENT [*4] |-> !FB_ENABLE)
      else $error("fieldbus active with config port connected");
   a_addr_zero: assert property ((ADDR_SWITCH == 7'h00) [*4] |-> !FB_ENABLE)
      else $error("fieldbus active with address zero");
   a_range_kept: assert property (RANGE_LIMIT)
      else $error("range limit dropped");
   a_block_pulse: assert property (DEV_BLOCK_INIT |-> LOOP_BUMPLESS
      && $past(LED_YELLOW) ##1 !DEV_BLOCK_INIT)
      else $error("alarm block init not a leave-standby pulse");
   a_bad_mode: assert property (FB_MODE_WR && FB_MODE_DATA == 2'h3 && !WR
      |-> ##2 FB_MODE == $past(FB_MODE, 2))
      else $error("mode value 3 changed the mode");
   a_cfg_entry: assert property ((!PC_PRESENT) [*3] ##0 (FB_MODE_WR && !WR
      && FB_MODE_DATA == MODE_CONFIG && FB_MODE == MODE_OPER)
      |-> ##2 FB_MODE == MODE_CONFIG && CFG_WRITE_EN)
      else $error("mode write of 2 did not enter config");
   // no command in this or the previous cycle means config must hold
   a_cfg_holds: assert property (CFG_WRITE_EN && !FB_MODE_WR && !WR
      && !$past(FB_MODE_WR) && !$past(WR) |=> CFG_WRITE_EN)
      else $error("config left without a command");

   c_cfg: cover property (CFG_WRITE_EN);
   c_stby: cover property (FB_MODE == MODE_STANDBY);
   c_leave: cover property (DEV_BLOCK_INIT);
endmodule
bind iosup_top iosup_chk u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET), .WR(WR),
   .PC_PRESENT(PC_PRESENT), .ADDR_SWITCH(ADDR_SWITCH),
   .FB_MODE_WR(FB_MODE_WR), .FB_MODE_DATA(FB_MODE_DATA), .FB_MODE(FB_MODE),
   .FB_ENABLE(FB_ENABLE), .CONTROL_RUN(CONTROL_RUN), .SAFE_STATE(SAFE_STATE),
   .INPUT_SCAN(INPUT_SCAN), .DEV_ALARM_EN(DEV_ALARM_EN),
   .FS_ALARM_EN(FS_ALARM_EN), .DEV_BLOCK_INIT(DEV_BLOCK_INIT),
   .LOOP_ZERO(LOOP_ZERO), .LOOP_BUMPLESS(LOOP_BUMPLESS),
   .RANGE_LIMIT(RANGE_LIMIT), .CFG_WRITE_EN(CFG_WRITE_EN),
   .LED_YELLOW(LED_YELLOW));

// >>> verification/iosup_fbm.sv
// fieldbus master model writing the operating-mode parameter
`timescale 1ns/100ps
module iosup_fbm (
   input  wire logic       sys_clk,
   output logic            fb_wr,
   output logic [1:0]      fb_data
);
   // idle bus shows a changed value, never the last one
   initial begin
      fb_wr   = 1'b0;
      fb_data = 2'h3;
   end
   // one-cycle mode write, released with inverted data
   // master sets the mode value
   // master sets the pace of writes
   task automatic send(input logic [1:0] v);
      @(posedge sys_clk);
      fb_wr   <= 1'b1;
      fb_data <= v;
      @(posedge sys_clk);
      fb_wr   <= 1'b0;
      fb_data <= ~v;
   endtask
endmodule

// >>> verification/iosup_top_test.sv
// self-checking bench for the io supervisor
`timescale 1ns/100ps
module iosup_top_test
   import iosup_pkg::*;
;
   typedef struct packed {
      logic [1:0] d;   // value written over the fieldbus
      logic [1:0] m;   // mode expected afterwards
   } iosup_row_t;
   logic       SYS_CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00;
   logic       PC_PRESENT = 1'b0, WD_TIMEOUT = 1'b0, MODULE_REMOVED = 1'b0;
   logic       TEST_PASS = 1'b1;
   logic [6:0] ADDR_SWITCH = 7'h05;
   logic       FB_MODE_WR, FB_ENABLE, CONTROL_RUN, SAFE_STATE, INPUT_SCAN;
   logic       DEV_ALARM_EN, FS_ALARM_EN, DEV_BLOCK_INIT, LOOP_ZERO;
   logic       LOOP_BUMPLESS, RANGE_LIMIT, CFG_WRITE_EN, LED_YELLOW;
   logic [1:0] FB_MODE_DATA, FB_MODE;
   logic [7:0] RDATA;
   logic [2:0] LED_TEST;
   int         mismatches = 0, total_checks = 0;
   // oper->stby->oper, bad value, config, held against 1 and 3, exit
   iosup_row_t rows [7] = '{'{2'h1, MODE_STANDBY}, '{2'h0, MODE_OPER},
      '{2'h3, MODE_OPER}, '{2'h2, MODE_CONFIG}, '{2'h1, MODE_CONFIG},
      '{2'h3, MODE_CONFIG}, '{2'h0, MODE_OPER}};

   // 100 MHz clock
   always #5 SYS_CLK = ~SYS_CLK;

   // short self test keeps the run small
   iosup_top #(.TEST_CYC(20), .STEP_CYC(4)) u_iosup_top (
      .SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .PC_PRESENT(PC_PRESENT),
      .WD_TIMEOUT(WD_TIMEOUT), .MODULE_REMOVED(MODULE_REMOVED),
      .TEST_PASS(TEST_PASS), .ADDR_SWITCH(ADDR_SWITCH),
      .FB_MODE_WR(FB_MODE_WR), .FB_MODE_DATA(FB_MODE_DATA),
      .FB_MODE(FB_MODE), .FB_ENABLE(FB_ENABLE), .CONTROL_RUN(CONTROL_RUN),
      .SAFE_STATE(SAFE_STATE), .INPUT_SCAN(INPUT_SCAN),
      .DEV_ALARM_EN(DEV_ALARM_EN), .FS_ALARM_EN(FS_ALARM_EN),
      .DEV_BLOCK_INIT(DEV_BLOCK_INIT), .LOOP_ZERO(LOOP_ZERO),
      .LOOP_BUMPLESS(LOOP_BUMPLESS), .RANGE_LIMIT(RANGE_LIMIT),
      .CFG_WRITE_EN(CFG_WRITE_EN), .LED_YELLOW(LED_YELLOW),
      .LED_TEST(LED_TEST));
   iosup_fbm u_iosup_fbm (.sys_clk(SYS_CLK), .fb_wr(FB_MODE_WR),
      .fb_data(FB_MODE_DATA));

   task automatic tick(input int n);
      repeat (n) @(posedge SYS_CLK);
   endtask
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   // one-cycle write strobe
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      WR <= 1'b1; ADDR <= a; WDATA <= d;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge SYS_CLK);
      RD <= 1'b1; ADDR <= a;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1 chk(RDATA === e, "register read");
   endtask
   // reset, then wait out self test and mode select
   task automatic boot();
      @(posedge SYS_CLK);
      RESET <= 1'b1;
      tick(5);
      #1 chk(SAFE_STATE === 1'b1 && LOOP_ZERO === 1'b1, "reset safe");
      RESET <= 1'b0;
      tick(40);
      #1;
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // hang guard, about seventy times the expected run
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end

   initial begin
      boot();
      chk(FB_MODE === MODE_OPER && CONTROL_RUN === 1'b1, "start oper");
      chk(FB_ENABLE === 1'b1, "fieldbus on");
      // table of fieldbus mode writes
      foreach (rows[i]) begin
         u_iosup_fbm.send(rows[i].d);
         tick(3);
         #1 chk(FB_MODE === rows[i].m, "mode out");
         chk(LED_YELLOW === (rows[i].m != MODE_OPER), "yellow led");
         rd_chk(ADDR_MODE, {6'h00, rows[i].m});
      end
      // config left by the control register exit pulse
      u_iosup_fbm.send(MODE_CONFIG);
      wr_reg(ADDR_CTRL, 8'h04);
      tick(2);
      #1 chk(FB_MODE === MODE_OPER, "ctrl exit");
      rd_chk(ADDR_BAUD, 8'h78);
      rd_chk(4'hf, 8'h00);
      // address switch limits
      ADDR_SWITCH <= 7'h00;
      tick(5);
      #1 chk(FB_ENABLE === 1'b0, "addr zero");
      rd_chk(ADDR_SLAVE, 8'h00);
      ADDR_SWITCH <= 7'h7f;
      tick(5);
      rd_chk(ADDR_SLAVE, 8'hff);
      // start-in-standby option through the reset-mode pulse
      wr_reg(ADDR_CTRL, 8'h01);
      wr_reg(ADDR_CTRL, 8'h09);
      tick(40);
      #1 chk(FB_MODE === MODE_STANDBY && INPUT_SCAN === 1'b1, "stby");
      chk(DEV_ALARM_EN === 1'b0 && FS_ALARM_EN === 1'b1, "alarms");
      u_iosup_fbm.send(MODE_OPER);
      tick(1);
      #1 chk(DEV_BLOCK_INIT === 1'b1, "block reinit");
      chk(LOOP_BUMPLESS === 1'b1 && LOOP_ZERO === 1'b0, "bumpless");
      chk(CONTROL_RUN === 1'b1, "resume no reset");
      // watchdog enabled and tripped
      wr_reg(ADDR_CTRL, 8'h02);
      WD_TIMEOUT <= 1'b1;
      tick(5);
      #1 chk(CONTROL_RUN === 1'b0 && SAFE_STATE === 1'b1, "wd stop");
      WD_TIMEOUT <= 1'b0;
      MODULE_REMOVED <= 1'b1;
      tick(5);
      #1 chk(CONTROL_RUN === 1'b0, "removed stop");
      MODULE_REMOVED <= 1'b0;
      // PC at power-up: config, fieldbus off and ignored
      PC_PRESENT <= 1'b1; // pc attached and silent before power-up
      boot();
      chk(FB_MODE === MODE_CONFIG && FB_ENABLE === 1'b0, "pc start");
      chk(LED_TEST === 3'h0, "test passed");
      rd_chk(ADDR_STATUS, 8'h16);
      u_iosup_fbm.send(MODE_OPER);
      tick(3);
      #1 chk(FB_MODE === MODE_CONFIG, "fb ignored");
      // failing self test shows on the test leds
      PC_PRESENT <= 1'b0;
      TEST_PASS <= 1'b0;
      boot();
      chk(LED_TEST === 3'h4, "test fail");
      wrap_up();
   end
endmodule
